// ==== core/power_module_command_map.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Code 01h is a read/write byte selecting run, shutdown or margin high/low.
// - Code 02h is a read/write byte choosing turn-on source; resets to 16h.
// - Send-byte 11h saves settings written since last restore into default store.
// - Send-byte 12h reloads working settings from the default store.
// - Send-byte 15h saves settings written since last restore into user store.
// - Send-byte 16h reloads working settings from the user store.
// - Code 20h is a read-only byte always returning 13h.
// - Code 23h is a signed read/write offset word; resets to 0000h.
// - Code 24h caps the setpoint; defaults to 1.1 times strapped output.
// - Codes 25h and 26h margin levels default to 1.05 and 0.95 strap.
// - Code 27h is the slew rate word; resets to BA00h.
// - Code 28h is the load-line slope word; resets to 0000h.
// - Code 32h is the duty ceiling word; resets to EADBh.
// - Code 33h is the switching frequency word; powers up from strap.
// - Code 37h is the phase offset word; default taken from bus address.
// - Code 38h is the sense resistance word; resets to BA2Ah.
// - Code 39h is the current-sense offset word; resets to BE00h.
// - Code 46h is the peak overcurrent threshold word; resets to E250h.
// - Code 4Bh is the valley undercurrent threshold word; resets to E5B0h.
// - Code 4Fh is the over-temperature threshold word; resets to EBE8h.
// - Fault action byte 80h disables the output with no retry.
module power_module_command_map (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Command port
	input wire logic cmd_valid,
	input wire pm_cmd_pkg::cmd_op_e cmd_op,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_err,
	// Strap and fault pins
	input wire logic [15:0] strap_vout,
	input wire logic [15:0] strap_freq,
	input wire logic [6:0] strap_addr,
	input wire logic fault_overvolt,
	input wire logic fault_undervolt,
	// Settings toward the power stage
	output logic [7:0] run_control,
	output logic [7:0] turn_on_source_config,
	output logic [15:0] output_setpoint,
	output logic [15:0] output_ceiling,
	output logic [15:0] margin_high_level,
	output logic [15:0] margin_low_level,
	output logic [15:0] output_slew_rate,
	output logic [15:0] load_line_slope,
	output logic [15:0] duty_ceiling,
	output logic [15:0] switch_frequency,
	output logic [15:0] phase_offset,
	output logic [15:0] peak_current_limit,
	output logic [15:0] valley_current_limit,
	output logic [15:0] overheat_limit,
	output logic output_shutdown
);
	import pm_cmd_pkg::*;

	logic [15:0] vout_meta, vout_sync, freq_meta, freq_sync;
	logic [6:0] addr_meta, addr_sync;
	logic [1:0] fault_meta, fault_sync;
	logic [15:0] work [NUM_REGS];
	logic [15:0] dflt_store [NUM_REGS];
	logic [15:0] user_store [NUM_REGS];
	logic [15:0] strap_val [NUM_REGS];
	logic [NUM_REGS-1:0] dirty;
	init_state_e state;
	logic hit;
	logic [IDX_W-1:0] hit_idx;
	logic take;
	logic write_ok;
	logic next_err;

	function automatic logic [15:0] scale(input logic [15:0] v, input int num, input int den);
		scale = 16'((32'(v) * 32'(num)) / 32'(den));
	endfunction : scale

	// Pins are asynchronous to mclk; the second stage is the only reader of the first.
	always_ff @(posedge mclk) begin
		vout_meta <= strap_vout;
		vout_sync <= vout_meta;
		freq_meta <= strap_freq;
		freq_sync <= freq_meta;
		addr_meta <= strap_addr;
		addr_sync <= addr_meta;
		fault_meta <= {fault_undervolt, fault_overvolt};
		fault_sync <= fault_meta;
	end

	// Strap values are only trusted once the synchronisers have filled.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= ST_SYNC;
		end else begin
			case (state)
				ST_SYNC: state <= ST_LOAD;
				ST_LOAD: state <= ST_READY;
				ST_READY: state <= ST_READY;
				default: state <= ST_SYNC;
			endcase
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			strap_val[i] = RESET_VALUE[i];
		end
		strap_val[IDX_SETPOINT] = vout_sync;
		strap_val[IDX_CEILING] = scale(vout_sync, CEIL_NUM, CEIL_DEN);
		strap_val[IDX_MARGIN_HIGH] = scale(vout_sync, MHIGH_NUM, MARGIN_DEN);
		strap_val[IDX_MARGIN_LOW] = scale(vout_sync, MLOW_NUM, MARGIN_DEN);
		strap_val[IDX_OV_LIMIT] = scale(vout_sync, OV_NUM, MARGIN_DEN);
		strap_val[IDX_UV_LIMIT] = scale(vout_sync, UV_NUM, MARGIN_DEN);
		strap_val[IDX_FREQ] = freq_sync;
		strap_val[IDX_PHASE] = {12'h000, addr_sync[3:0]};
	end

	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (REG_CODE[i] == cmd_code) begin
				hit = 1'b1;
				hit_idx = IDX_W'(i);
			end
		end
	end

	assign take = cmd_valid && (state == ST_READY);

	// A write lands only on a writable code with the matching transfer width.
	always_comb begin
		write_ok = 1'b0;
		if (hit && !REG_IS_RO[hit_idx]) begin
			if (cmd_op == OP_WRITE_BYTE) begin
				write_ok = REG_IS_BYTE[hit_idx];
			end else if (cmd_op == OP_WRITE_WORD) begin
				write_ok = !REG_IS_BYTE[hit_idx];
			end
		end
	end

	always_comb begin
		next_err = 1'b0;
		case (cmd_op)
			OP_SEND: next_err = !(cmd_code == CODE_STORE_DEFAULT || cmd_code == CODE_RESTORE_DEFAULT ||
				cmd_code == CODE_STORE_USER || cmd_code == CODE_RESTORE_USER);
			OP_WRITE_BYTE: next_err = !write_ok;
			OP_WRITE_WORD: next_err = !write_ok;
			OP_READ: next_err = !hit;
			default: next_err = 1'b1;
		endcase
	end

	// Stores copy only entries written since the last restore; the entries stay marked
	// until a restore, so a second store after more writes still catches the earlier ones.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				work[i] <= RESET_VALUE[i];
				dflt_store[i] <= RESET_VALUE[i];
				user_store[i] <= RESET_VALUE[i];
			end
			dirty <= '0;
		end else if (state == ST_LOAD) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				work[i] <= strap_val[i];
				dflt_store[i] <= strap_val[i];
				user_store[i] <= strap_val[i];
			end
		end else if (take) begin
			if (cmd_op == OP_SEND) begin
				case (cmd_code)
					CODE_STORE_DEFAULT: begin
						for (int i = 0; i < NUM_REGS; i++) begin
							if (dirty[i]) begin
								dflt_store[i] <= work[i];
							end
						end
					end
					CODE_RESTORE_DEFAULT: begin
						for (int i = 0; i < NUM_REGS; i++) begin
							work[i] <= dflt_store[i];
						end
						dirty <= '0;
					end
					CODE_STORE_USER: begin
						for (int i = 0; i < NUM_REGS; i++) begin
							if (dirty[i]) begin
								user_store[i] <= work[i];
							end
						end
					end
					CODE_RESTORE_USER: begin
						for (int i = 0; i < NUM_REGS; i++) begin
							work[i] <= user_store[i];
						end
						dirty <= '0;
					end
					default: begin
					end
				endcase
			end else if (write_ok) begin
				work[hit_idx] <= REG_IS_BYTE[hit_idx] ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
				dirty[hit_idx] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_err <= 1'b0;
		end else begin
			rsp_valid <= take;
			rsp_err <= take && next_err;
			rsp_data <= (take && cmd_op == OP_READ && hit) ? work[hit_idx] : 16'h0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= (state == ST_LOAD) || (state == ST_READY);
		end
	end

	// No retry: once tripped the output stays off until the next reset.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			output_shutdown <= 1'b0;
		end else if ((fault_sync[0] && work[IDX_OV_ACTION][7:0] == FAULT_ACTION_OFF) ||
			(fault_sync[1] && work[IDX_UV_ACTION][7:0] == FAULT_ACTION_OFF)) begin
			output_shutdown <= 1'b1;
		end
	end

	assign run_control = work[IDX_RUN][7:0];
	assign turn_on_source_config = work[IDX_TURN_ON][7:0];
	assign output_setpoint = work[IDX_SETPOINT];
	assign output_ceiling = work[IDX_CEILING];
	assign margin_high_level = work[IDX_MARGIN_HIGH];
	assign margin_low_level = work[IDX_MARGIN_LOW];
	assign output_slew_rate = work[IDX_SLEW];
	assign load_line_slope = work[IDX_SLOPE];
	assign duty_ceiling = work[IDX_DUTY];
	assign switch_frequency = work[IDX_FREQ];
	assign phase_offset = work[IDX_PHASE];
	assign peak_current_limit = work[IDX_PEAK_LIMIT];
	assign valley_current_limit = work[IDX_VALLEY_LIMIT];
	assign overheat_limit = work[IDX_OVERHEAT_LIMIT];

	chk_format_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
		work[IDX_FORMAT] == RST_FORMAT) else $error("format byte changed");

	chk_ro_write_err: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op != OP_READ && cmd_op != OP_SEND && cmd_code == CODE_FORMAT) |=> rsp_err && rsp_valid)
		else $error("write to read-only code not flagged");

	chk_run_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_BYTE && cmd_code == CODE_RUN) |=> run_control == $past(cmd_wdata[7:0]))
		else $error("run control not written");

	chk_word_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && write_ok) ##1 (take && cmd_op == OP_READ && cmd_code == $past(cmd_code))
		|=> rsp_data == $past(cmd_wdata, 2)) else $error("word read back differs");

	chk_reset_values: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> turn_on_source_config == RST_TURN_ON[7:0] && output_slew_rate == RST_SLEW &&
		duty_ceiling == RST_DUTY && overheat_limit == RST_OVERHEAT_LIMIT) else $error("bad reset value");

	chk_restore_user: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_SEND && cmd_code == CODE_RESTORE_USER) |=>
		output_setpoint == $past(user_store[IDX_SETPOINT]) && dirty == '0) else $error("user restore failed");

	chk_restore_default: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_SEND && cmd_code == CODE_RESTORE_DEFAULT) |=>
		duty_ceiling == $past(dflt_store[IDX_DUTY])) else $error("default restore failed");

	chk_store_user: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_SEND && cmd_code == CODE_STORE_USER && dirty[IDX_SETPOINT]) |=>
		user_store[IDX_SETPOINT] == $past(output_setpoint)) else $error("user store failed");

	chk_store_default: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_SEND && cmd_code == CODE_STORE_DEFAULT && !dirty[IDX_SLEW]) |=>
		$stable(dflt_store[IDX_SLEW])) else $error("clean entry stored");

	chk_fault_off: assert property (@(posedge mclk) disable iff (!rst_n)
		(fault_sync[0] && work[IDX_OV_ACTION][7:0] == FAULT_ACTION_OFF) |=> output_shutdown [*3])
		else $error("fault did not latch shutdown");

	// Each setting output except the setpoint and the high margin level must follow its own code, so a swapped bank index there shows up here.
	chk_turn_on_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_BYTE && cmd_code == CODE_TURN_ON) |=>
		turn_on_source_config == $past(cmd_wdata[7:0])) else $error("turn-on source not written");

	chk_ceiling_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_CEILING) |=> output_ceiling == $past(cmd_wdata))
		else $error("output ceiling not written");

	chk_margin_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_MARGIN_LOW) |=> margin_low_level == $past(cmd_wdata))
		else $error("low margin level not written");

	chk_slew_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_SLEW) |=> output_slew_rate == $past(cmd_wdata))
		else $error("slew rate not written");

	chk_slope_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_SLOPE) |=> load_line_slope == $past(cmd_wdata))
		else $error("load-line slope not written");

	chk_duty_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_DUTY) |=> duty_ceiling == $past(cmd_wdata))
		else $error("duty ceiling not written");

	chk_freq_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_FREQ) |=> switch_frequency == $past(cmd_wdata))
		else $error("switching frequency not written");

	chk_phase_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_PHASE) |=> phase_offset == $past(cmd_wdata))
		else $error("phase offset not written");

	chk_peak_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_PEAK_LIMIT) |=> peak_current_limit == $past(cmd_wdata))
		else $error("peak current limit not written");

	chk_valley_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_VALLEY_LIMIT) |=>
		valley_current_limit == $past(cmd_wdata)) else $error("valley current limit not written");

	chk_overheat_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_OVERHEAT_LIMIT) |=> overheat_limit == $past(cmd_wdata))
		else $error("overheat limit not written");

	chk_shutdown_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		output_shutdown |=> output_shutdown) else $error("shutdown released without reset");

	chk_width_refused: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && cmd_op == OP_WRITE_WORD && cmd_code == CODE_RUN) |=> $stable(run_control) && rsp_err)
		else $error("word write to byte code not refused");

endmodule : power_module_command_map

// ==== core/pm_cmd_pkg.sv ====
package pm_cmd_pkg;

	localparam int NUM_REGS = 23;
	localparam int IDX_W = 5;

	// Command codes of the stored settings.
	localparam logic [7:0] CODE_RUN = 8'h01;
	localparam logic [7:0] CODE_TURN_ON = 8'h02;
	localparam logic [7:0] CODE_FORMAT = 8'h20;
	localparam logic [7:0] CODE_SETPOINT = 8'h21;
	localparam logic [7:0] CODE_TRIM = 8'h22;
	localparam logic [7:0] CODE_CAL_OFFSET = 8'h23;
	localparam logic [7:0] CODE_CEILING = 8'h24;
	localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
	localparam logic [7:0] CODE_MARGIN_LOW = 8'h26;
	localparam logic [7:0] CODE_SLEW = 8'h27;
	localparam logic [7:0] CODE_SLOPE = 8'h28;
	localparam logic [7:0] CODE_DUTY = 8'h32;
	localparam logic [7:0] CODE_FREQ = 8'h33;
	localparam logic [7:0] CODE_PHASE = 8'h37;
	localparam logic [7:0] CODE_SENSE_GAIN = 8'h38;
	localparam logic [7:0] CODE_SENSE_OFFSET = 8'h39;
	localparam logic [7:0] CODE_OV_LIMIT = 8'h40;
	localparam logic [7:0] CODE_OV_ACTION = 8'h41;
	localparam logic [7:0] CODE_UV_LIMIT = 8'h44;
	localparam logic [7:0] CODE_UV_ACTION = 8'h45;
	localparam logic [7:0] CODE_PEAK_LIMIT = 8'h46;
	localparam logic [7:0] CODE_VALLEY_LIMIT = 8'h4B;
	localparam logic [7:0] CODE_OVERHEAT_LIMIT = 8'h4F;

	// Data-less trigger codes.
	localparam logic [7:0] CODE_STORE_DEFAULT = 8'h11;
	localparam logic [7:0] CODE_RESTORE_DEFAULT = 8'h12;
	localparam logic [7:0] CODE_STORE_USER = 8'h15;
	localparam logic [7:0] CODE_RESTORE_USER = 8'h16;

	// Bank indices.
	localparam logic [IDX_W-1:0] IDX_RUN = 5'h00;
	localparam logic [IDX_W-1:0] IDX_TURN_ON = 5'h01;
	localparam logic [IDX_W-1:0] IDX_FORMAT = 5'h02;
	localparam logic [IDX_W-1:0] IDX_SETPOINT = 5'h03;
	localparam logic [IDX_W-1:0] IDX_CEILING = 5'h06;
	localparam logic [IDX_W-1:0] IDX_MARGIN_HIGH = 5'h07;
	localparam logic [IDX_W-1:0] IDX_MARGIN_LOW = 5'h08;
	localparam logic [IDX_W-1:0] IDX_SLEW = 5'h09;
	localparam logic [IDX_W-1:0] IDX_SLOPE = 5'h0A;
	localparam logic [IDX_W-1:0] IDX_DUTY = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_FREQ = 5'h0C;
	localparam logic [IDX_W-1:0] IDX_PHASE = 5'h0D;
	localparam logic [IDX_W-1:0] IDX_SENSE_GAIN = 5'h0E;
	localparam logic [IDX_W-1:0] IDX_SENSE_OFFSET = 5'h0F;
	localparam logic [IDX_W-1:0] IDX_OV_LIMIT = 5'h10;
	localparam logic [IDX_W-1:0] IDX_OV_ACTION = 5'h11;
	localparam logic [IDX_W-1:0] IDX_UV_LIMIT = 5'h12;
	localparam logic [IDX_W-1:0] IDX_UV_ACTION = 5'h13;
	localparam logic [IDX_W-1:0] IDX_PEAK_LIMIT = 5'h14;
	localparam logic [IDX_W-1:0] IDX_VALLEY_LIMIT = 5'h15;
	localparam logic [IDX_W-1:0] IDX_OVERHEAT_LIMIT = 5'h16;

	// Reset values.
	localparam logic [15:0] RST_RUN = 16'h0000;
	localparam logic [15:0] RST_TURN_ON = 16'h0016;
	localparam logic [15:0] RST_FORMAT = 16'h0013;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_SLEW = 16'hBA00;
	localparam logic [15:0] RST_DUTY = 16'hEADB;
	localparam logic [15:0] RST_SENSE_GAIN = 16'hBA2A;
	localparam logic [15:0] RST_SENSE_OFFSET = 16'hBE00;
	localparam logic [15:0] RST_ACTION = 16'h0080;
	localparam logic [15:0] RST_PEAK_LIMIT = 16'hE250;
	localparam logic [15:0] RST_VALLEY_LIMIT = 16'hE5B0;
	localparam logic [15:0] RST_OVERHEAT_LIMIT = 16'hEBE8;

	// Action byte meaning disable the output and never retry.
	localparam logic [7:0] FAULT_ACTION_OFF = 8'h80;

	// Strap scale factors as numerator over denominator.
	localparam int CEIL_NUM = 11;
	localparam int CEIL_DEN = 10;
	localparam int MHIGH_NUM = 21;
	localparam int MLOW_NUM = 19;
	localparam int OV_NUM = 23;
	localparam int UV_NUM = 17;
	localparam int MARGIN_DEN = 20;

	localparam logic [7:0] REG_CODE [NUM_REGS] = '{
		CODE_RUN, CODE_TURN_ON, CODE_FORMAT, CODE_SETPOINT, CODE_TRIM, CODE_CAL_OFFSET,
		CODE_CEILING, CODE_MARGIN_HIGH, CODE_MARGIN_LOW, CODE_SLEW, CODE_SLOPE, CODE_DUTY,
		CODE_FREQ, CODE_PHASE, CODE_SENSE_GAIN, CODE_SENSE_OFFSET, CODE_OV_LIMIT, CODE_OV_ACTION,
		CODE_UV_LIMIT, CODE_UV_ACTION, CODE_PEAK_LIMIT, CODE_VALLEY_LIMIT, CODE_OVERHEAT_LIMIT};

	localparam logic [NUM_REGS-1:0] REG_IS_BYTE = 23'b000_1010_0000_0000_0000_0111;
	localparam logic [NUM_REGS-1:0] REG_IS_RO = 23'b000_0000_0000_0000_0000_0100;

	localparam logic [15:0] RESET_VALUE [NUM_REGS] = '{
		RST_RUN, RST_TURN_ON, RST_FORMAT, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_SLEW, RST_ZERO, RST_DUTY,
		RST_ZERO, RST_ZERO, RST_SENSE_GAIN, RST_SENSE_OFFSET, RST_ZERO, RST_ACTION,
		RST_ZERO, RST_ACTION, RST_PEAK_LIMIT, RST_VALLEY_LIMIT, RST_OVERHEAT_LIMIT};

	typedef enum logic [1:0] {
		OP_SEND = 2'b00,
		OP_WRITE_BYTE = 2'b01,
		OP_WRITE_WORD = 2'b10,
		OP_READ = 2'b11
	} cmd_op_e;

	typedef enum logic [1:0] {
		ST_SYNC = 2'b00,
		ST_LOAD = 2'b01,
		ST_READY = 2'b10
	} init_state_e;

endpackage : pm_cmd_pkg

// ==== sim/pm_host_model.sv ====
`timescale 1ns/1ps
module pm_host_model (
	// Clock
	input wire logic mclk,
	// Request side
	output logic cmd_valid,
	output pm_cmd_pkg::cmd_op_e cmd_op,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	// Response side
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic rsp_err
);
	import pm_cmd_pkg::*;

	initial begin
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// Called at a falling edge; the request stays up so that a following call can run back to back.
	task xfer(input cmd_op_e op, input logic [7:0] code, input logic [15:0] wdata, output logic got,
		output logic [15:0] data, output logic err);
		while (cmd_ready !== 1'b1) begin
			@(negedge mclk);
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_code = code;
		cmd_wdata = wdata;
		@(posedge mclk);
		@(negedge mclk);
		got = rsp_valid;
		data = rsp_data;
		err = rsp_err;
	endtask : xfer

	// The released code and data fields are scrambled so that no stale value can pass for a real one.
	task idle();
		cmd_valid = 1'b0;
		cmd_code = ~cmd_code;
		cmd_wdata = ~cmd_wdata;
	endtask : idle

endmodule : pm_host_model

// ==== sim/power_module_command_map_tb_top.sv ====
`timescale 1ns/1ps
module power_module_command_map_tb_top;
	import pm_cmd_pkg::*;

	localparam logic [15:0] SV = 16'h2000;
	localparam logic [15:0] SF = 16'h1234;
	localparam logic [31:0] SV32 = {16'h0000, SV};
	localparam logic [15:0] CEIL = 16'((SV32 * 32'd11) / 32'd10);
	localparam logic [15:0] MHI = 16'((SV32 * 32'd21) / 32'd20);
	localparam logic [15:0] MLO = 16'((SV32 * 32'd19) / 32'd20);
	localparam logic [15:0] OVL = 16'((SV32 * 32'd23) / 32'd20);
	localparam logic [15:0] UVL = 16'((SV32 * 32'd17) / 32'd20);
	// Expected reset values, in the order of the bank's code table.
	localparam logic [15:0] RV [23] = '{16'h0000, 16'h0016, 16'h0013, SV, 16'h0000, 16'h0000, CEIL, MHI, MLO,
		16'hBA00, 16'h0000, 16'hEADB, SF, 16'h0005, 16'hBA2A, 16'hBE00, OVL, 16'h0080, UVL, 16'h0080,
		16'hE250, 16'hE5B0, 16'hEBE8};

	logic mclk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_err, fault_overvolt, fault_undervolt;
	cmd_op_e cmd_op;
	logic [7:0] cmd_code, run_control, turn_on_source_config;
	logic [15:0] cmd_wdata, rsp_data, strap_vout, strap_freq;
	logic [6:0] strap_addr;
	logic [15:0] output_setpoint, output_ceiling, margin_high_level, margin_low_level, output_slew_rate;
	logic [15:0] load_line_slope, duty_ceiling, switch_frequency, phase_offset, peak_current_limit;
	logic [15:0] valley_current_limit, overheat_limit;
	logic output_shutdown;
	int num_errors = 0;
	int samples_checked = 0;

	power_module_command_map i_dut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_err(rsp_err), .strap_vout(strap_vout), .strap_freq(strap_freq),
		.strap_addr(strap_addr), .fault_overvolt(fault_overvolt), .fault_undervolt(fault_undervolt),
		.run_control(run_control), .turn_on_source_config(turn_on_source_config),
		.output_setpoint(output_setpoint), .output_ceiling(output_ceiling),
		.margin_high_level(margin_high_level), .margin_low_level(margin_low_level),
		.output_slew_rate(output_slew_rate), .load_line_slope(load_line_slope), .duty_ceiling(duty_ceiling),
		.switch_frequency(switch_frequency), .phase_offset(phase_offset),
		.peak_current_limit(peak_current_limit), .valley_current_limit(valley_current_limit),
		.overheat_limit(overheat_limit), .output_shutdown(output_shutdown));

	pm_host_model i_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_err(rsp_err));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task chk(input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : chk

	task finish_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	function automatic logic is_byte(input logic [7:0] code);
		return code == 8'h01 || code == 8'h02 || code == 8'h20 || code == 8'h41 || code == 8'h45;
	endfunction : is_byte

	task io(input cmd_op_e op, input logic [7:0] code, input logic [15:0] d, input logic ee,
		input logic [15:0] ed);
		logic g;
		logic e;
		logic [15:0] q;
		i_host.xfer(op, code, d, g, q, e);
		chk({15'h0000, g}, 16'h0001);
		chk({15'h0000, e}, {15'h0000, ee});
		if (op == OP_READ && !ee) begin
			chk(q, ed);
		end
	endtask : io

	task wr(input logic [7:0] code, input logic [15:0] d);
		io(is_byte(code) ? OP_WRITE_BYTE : OP_WRITE_WORD, code, d, 1'b0, 16'h0000);
	endtask : wr

	task rd(input logic [7:0] code, input logic [15:0] ed);
		io(OP_READ, code, 16'h0000, 1'b0, ed);
	endtask : rd

	initial begin
		logic [15:0] p;
		rst_n = 1'b0;
		strap_vout = SV;
		strap_freq = SF;
		strap_addr = 7'h15;
		fault_overvolt = 1'b0;
		fault_undervolt = 1'b0;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		chk({15'h0000, cmd_ready}, 16'h0000);
		for (int i = 0; i < 23; i++) begin
			rd(REG_CODE[i], RV[i]);
		end
		i_host.idle();
		@(negedge mclk);
		chk({8'h00, turn_on_source_config}, 16'h0016);
		chk(duty_ceiling, 16'hEADB);
		chk(output_ceiling, CEIL);
		chk({15'h0000, cmd_ready}, 16'h0001);
		chk({8'h00, run_control}, 16'h0000);
		chk(margin_high_level, MHI);
		chk(margin_low_level, MLO);
		chk(load_line_slope, 16'h0000);
		chk(switch_frequency, SF);
		chk(phase_offset, 16'h0005);
		chk(peak_current_limit, 16'hE250);
		chk(valley_current_limit, 16'hE5B0);
		chk(overheat_limit, 16'hEBE8);
		// Every writable code is written and read straight back in the next cycle.
		for (int i = 0; i < 23; i++) begin
			p = is_byte(REG_CODE[i]) ? {8'h00, 8'hA0 ^ 8'(i)} : 16'h5A00 ^ 16'(i * 16'h0111);
			if (REG_CODE[i] != 8'h20) begin
				wr(REG_CODE[i], p);
				rd(REG_CODE[i], p);
			end
		end
		foreach (p[i]) begin
			if (i < 4) begin
				wr(8'h01, {8'h00, 8'(i * 8'h24)});
				rd(8'h01, {8'h00, 8'(i * 8'h24)});
			end
		end
		io(OP_WRITE_BYTE, 8'h20, 16'h00FF, 1'b1, 16'h0000);
		rd(8'h20, 16'h0013);
		io(OP_SEND, 8'h03, 16'h0000, 1'b1, 16'h0000);
		io(OP_READ, 8'h03, 16'h0000, 1'b1, 16'h0000);
		io(OP_WRITE_BYTE, 8'h22, 16'h0011, 1'b1, 16'h0000);
		io(OP_WRITE_WORD, 8'h01, 16'h0011, 1'b1, 16'h0000);
		wr(8'h22, 16'h1111);
		io(OP_SEND, 8'h15, 16'h0000, 1'b0, 16'h0000);
		wr(8'h22, 16'h2222);
		io(OP_SEND, 8'h16, 16'h0000, 1'b0, 16'h0000);
		rd(8'h22, 16'h1111);
		// The setpoint was written in the sweep and is still marked, so the user store took it.
		chk(output_setpoint, 16'h5933);
		io(OP_SEND, 8'h12, 16'h0000, 1'b0, 16'h0000);
		rd(8'h22, 16'h0000);
		rd(8'h27, 16'hBA00);
		chk(output_setpoint, SV);
		wr(8'h22, 16'h3333);
		io(OP_SEND, 8'h11, 16'h0000, 1'b0, 16'h0000);
		wr(8'h22, 16'h4444);
		io(OP_SEND, 8'h12, 16'h0000, 1'b0, 16'h0000);
		rd(8'h22, 16'h3333);
		chk(output_slew_rate, 16'hBA00);
		wr(8'h45, 16'h0000);
		i_host.idle();
		fault_undervolt = 1'b1;
		repeat (6) @(negedge mclk);
		chk({15'h0000, output_shutdown}, 16'h0000);
		fault_overvolt = 1'b1;
		repeat (6) @(negedge mclk);
		chk({15'h0000, output_shutdown}, 16'h0001);
		finish_test();
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		finish_test();
	end

endmodule : power_module_command_map_tb_top
